// ===== logic/scisr_regs.vh
`ifndef SCISR_REGS_VH
`define SCISR_REGS_VH

// ********************************
// register addresses
// ********************************
`define SCISR_ADDR_STATUS1     8'h00
`define SCISR_ADDR_STATUS2     8'h01
`define SCISR_ADDR_VOLT        8'h02
`define SCISR_ADDR_TONE        8'h03
`define SCISR_ADDR_CURR        8'h04

// ********************************
// reset values
// ********************************
`define SCISR_RST_VOLT         8'h00
`define SCISR_RST_TONE         8'h00
`define SCISR_RST_CURR         8'h00

// ********************************
// field positions
// ********************************
`define SCISR_VOLT_SEL_MSB     3
`define SCISR_VOLT_SEL_LSB     0
`define SCISR_TONE_ON_BIT      0
`define SCISR_LOW_POWER_BIT    1
`define SCISR_TONE_SRC_BIT     2
`define SCISR_LIMIT_RANGE_BIT  0
`define SCISR_BOOST_LIMIT_BIT  1
`define SCISR_PULSED_OFF_BIT   2
`define SCISR_PULSE_LONG_BIT   3

// ********************************
// chip address (arbitrary value)
// ********************************
`define SCISR_CHIP_ADDR_HI     6'h04

// ********************************
// timing counts
// ********************************
`define SCISR_SYNC_STAGES      2
`define SCISR_BITS_PER_BYTE    4'h8
`define SCISR_LAST_TX_BIT      3'h7

`endif

// ===== logic/scisr_sync.v
`timescale 1ns/1ps

// ********************************
// two-stage synchroniser per bit
// ********************************
module scisr_sync #(
   parameter W = 1
) (
   // clock and reset
   input  wire         mclk_i,
   input  wire         rst_i,
   // data
   input  wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);

   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         reg meta_r;
         reg stab_r;
         // first stage feeds only the second
         always @(posedge mclk_i) begin
            if (rst_i) begin
               meta_r <= 1'b0;
               stab_r <= 1'b0;
            end else begin
               meta_r <= async_i[g];
               stab_r <= meta_r;
            end
         end
         assign sync_o[g] = stab_r;
      end
   endgenerate

endmodule // scisr_sync

// ===== logic/scisr_i2c_regs.v
`timescale 1ns/1ps
`include "scisr_regs.vh"

module scisr_i2c_regs (
   // clock and reset
   input  wire       mclk_i,
   input  wire       rst_i,
   // bus pins
   input  wire       scl_i,
   input  wire       sda_i,
   output reg        sda_o,
   output reg        sda_oe_o,
   // device pins
   input  wire       addr_sel_i,
   input  wire       uvlo_i,
   input  wire       tone_key_input_i,
   // diagnostics from analog side, same clock
   input  wire [7:0] status1_i,
   input  wire [7:0] status2_i,
   // voltage control
   output reg  [3:0] volt_sel_o,
   // tone control
   output reg        tone_output_on_o,
   output reg        low_power_select_o,
   output reg        tone_input_source_o,
   output reg        tone_ext_pass_o,
   output reg        tone_env_gate_o,
   // current limit control
   output reg        output_limit_range_o,
   output reg        boost_switch_limit_o,
   output reg        pulsed_limit_off_o,
   output reg        pulse_time_long_o
);

   // ********************************
   // states
   // ********************************
   localparam S_IDLE = 3'h0;
   localparam S_RX   = 3'h1;
   localparam S_ACK  = 3'h2;
   localparam S_TX   = 3'h3;
   localparam S_MACK = 3'h4;

   localparam P_CHIP = 2'h0;
   localparam P_REG  = 2'h1;
   localparam P_DATA = 2'h2;

   // ********************************
   // pin synchronisers
   // ********************************
   wire [4:0] pin_sync;

   scisr_sync #(
      .W (5)
   ) u_sync (
      .mclk_i  (mclk_i),
      .rst_i   (rst_i),
      .async_i ({tone_key_input_i, uvlo_i, addr_sel_i, ~sda_i, ~scl_i}),
      .sync_o  (pin_sync)
   );

   // bus pins pass inverted so a cleared stage reads idle high, no false edge after reset
   wire scl_s  = ~pin_sync[0];
   wire sda_s  = ~pin_sync[1];
   wire asel_s = pin_sync[2];
   wire uvlo_s = pin_sync[3];
   wire key_s  = pin_sync[4];

   reg        scl_d_r;
   reg        sda_d_r;
   reg  [2:0] state_r;
   reg  [1:0] phase_r;
   reg  [3:0] bit_cnt_r;
   reg  [7:0] shift_r;
   reg  [7:0] ptr_r;
   reg        rw_r;
   reg        mack_low_r;
   reg  [7:0] volt_r;
   reg  [7:0] tone_r;
   reg  [7:0] curr_r;

   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   // data edges only count while clock stays high
   wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

   wire [6:0] chip_addr = {`SCISR_CHIP_ADDR_HI, asel_s};
   wire       addr_hit  = (shift_r[7:1] == chip_addr);

   // ********************************
   // read mux
   // ********************************
   function [7:0] rd_mux;
      input [7:0] a;
      input [7:0] st1;
      input [7:0] st2;
      input [7:0] v;
      input [7:0] t;
      input [7:0] c;
      begin
         case (a)
            `SCISR_ADDR_STATUS1: rd_mux = st1;
            `SCISR_ADDR_STATUS2: rd_mux = st2;
            `SCISR_ADDR_VOLT:    rd_mux = v;
            `SCISR_ADDR_TONE:    rd_mux = t;
            `SCISR_ADDR_CURR:    rd_mux = c;
            default:             rd_mux = 8'h00;
         endcase
      end
   endfunction

   wire [7:0] ptr_inc  = ptr_r + 8'h01;
   wire [7:0] rd_cur   = rd_mux(ptr_r, status1_i, status2_i, volt_r, tone_r, curr_r);
   wire [7:0] rd_next  = rd_mux(ptr_inc, status1_i, status2_i, volt_r, tone_r, curr_r);

   // ********************************
   // edge history
   // ********************************
   always @(posedge mclk_i) begin
      if (rst_i) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // ********************************
   // protocol engine
   // ********************************
   always @(posedge mclk_i) begin
      if (rst_i) begin
         state_r    <= S_IDLE;
         phase_r    <= P_CHIP;
         bit_cnt_r  <= 4'h0;
         shift_r    <= 8'h00;
         ptr_r      <= 8'h00;
         rw_r       <= 1'b0;
         mack_low_r <= 1'b0;
         sda_o      <= 1'b0;
         sda_oe_o   <= 1'b0;
         volt_r     <= `SCISR_RST_VOLT;
         tone_r     <= `SCISR_RST_TONE;
         curr_r     <= `SCISR_RST_CURR;
      end else if (stop_det) begin
         state_r   <= S_IDLE;
         phase_r   <= P_CHIP;
         sda_oe_o  <= 1'b0;
      end else if (start_det) begin
         state_r   <= S_RX;
         phase_r   <= P_CHIP;
         bit_cnt_r <= 4'h0;
         sda_oe_o  <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: begin
               sda_oe_o <= 1'b0;
            end
            S_RX: begin
               if (scl_rise && bit_cnt_r != `SCISR_BITS_PER_BYTE) begin
                  shift_r   <= {shift_r[6:0], sda_s};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall && bit_cnt_r == `SCISR_BITS_PER_BYTE) begin
                  if (uvlo_s) begin
                     state_r <= S_IDLE;
                  end else if (phase_r == P_CHIP && !addr_hit) begin
                     state_r <= S_IDLE;
                  end else begin
                     state_r  <= S_ACK;
                     sda_oe_o <= 1'b1;
                     case (phase_r)
                        P_CHIP: begin
                           rw_r <= shift_r[0];
                        end
                        P_REG: begin
                           ptr_r <= shift_r;
                        end
                        default: begin
                           ptr_r <= ptr_inc;
                           if (ptr_r == `SCISR_ADDR_VOLT) begin
                              volt_r <= shift_r;
                           end
                           if (ptr_r == `SCISR_ADDR_TONE) begin
                              tone_r <= shift_r;
                           end
                           if (ptr_r == `SCISR_ADDR_CURR) begin
                              curr_r <= shift_r;
                           end
                        end
                     endcase
                  end
               end
            end
            S_ACK: begin
               // hold low until ninth clock falls
               if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  if (phase_r == P_CHIP && rw_r) begin
                     state_r   <= S_TX;
                     shift_r   <= rd_cur;
                     sda_oe_o  <= ~rd_cur[7];
                  end else begin
                     state_r  <= S_RX;
                     sda_oe_o <= 1'b0;
                     if (phase_r == P_CHIP) begin
                        phase_r <= P_REG;
                     end else begin
                        phase_r <= P_DATA;
                     end
                  end
               end
            end
            S_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_r[2:0] == `SCISR_LAST_TX_BIT) begin
                     // release for master acknowledge
                     state_r  <= S_MACK;
                     sda_oe_o <= 1'b0;
                  end else begin
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                     shift_r   <= {shift_r[6:0], 1'b0};
                     sda_oe_o  <= ~shift_r[6];
                  end
               end
            end
            S_MACK: begin
               if (scl_rise) begin
                  mack_low_r <= ~sda_s;
               end else if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  if (mack_low_r) begin
                     state_r  <= S_TX;
                     ptr_r    <= ptr_inc;
                     shift_r  <= rd_next;
                     sda_oe_o <= ~rd_next[7];
                  end else begin
                     // high ack: wait for stop
                     state_r  <= S_IDLE;
                     sda_oe_o <= 1'b0;
                  end
               end
            end
            default: begin
               state_r  <= S_IDLE;
               sda_oe_o <= 1'b0;
            end
         endcase
      end
   end

   // ********************************
   // control outputs
   // ********************************
   // reserved bits dropped here, stored only for readback
   // reserved bits drive no control output
   always @(posedge mclk_i) begin
      if (rst_i) begin
         volt_sel_o           <= 4'h0;
         tone_output_on_o     <= 1'b0;
         low_power_select_o   <= 1'b0;
         tone_input_source_o  <= 1'b0;
         tone_ext_pass_o      <= 1'b0;
         tone_env_gate_o      <= 1'b0;
         output_limit_range_o <= 1'b0;
         boost_switch_limit_o <= 1'b0;
         pulsed_limit_off_o   <= 1'b0;
         pulse_time_long_o    <= 1'b0;
      end else begin
         volt_sel_o           <= volt_r[`SCISR_VOLT_SEL_MSB:`SCISR_VOLT_SEL_LSB];
         tone_output_on_o     <= tone_r[`SCISR_TONE_ON_BIT];
         low_power_select_o   <= tone_r[`SCISR_LOW_POWER_BIT];
         tone_input_source_o  <= tone_r[`SCISR_TONE_SRC_BIT];
         tone_ext_pass_o      <= tone_r[`SCISR_TONE_ON_BIT] & tone_r[`SCISR_TONE_SRC_BIT] & key_s;
         tone_env_gate_o      <= tone_r[`SCISR_TONE_ON_BIT] & ~tone_r[`SCISR_TONE_SRC_BIT] & key_s;
         output_limit_range_o <= curr_r[`SCISR_LIMIT_RANGE_BIT];
         boost_switch_limit_o <= curr_r[`SCISR_BOOST_LIMIT_BIT];
         pulsed_limit_off_o   <= curr_r[`SCISR_PULSED_OFF_BIT];
         pulse_time_long_o    <= curr_r[`SCISR_PULSE_LONG_BIT];
      end
   end

endmodule // scisr_i2c_regs

// ===== bench/scisr_i2c_regs_asserts.sv
`timescale 1ns/1ps
// ****************************
// bus pin and control checks
// ****************************
module scisr_i2c_regs_asserts (
   // clock and reset
   input wire logic       mclk_i,
   input wire logic       rst_i,
   // pins
   input wire logic       scl_i,
   input wire logic       uvlo_i,
   input wire logic       tone_key_input_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   // controls
   input wire logic [3:0] volt_sel_o,
   input wire logic       tone_output_on_o,
   input wire logic       tone_input_source_o,
   input wire logic       tone_ext_pass_o,
   input wire logic       tone_env_gate_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_ext_on;
      (tone_key_input_i && tone_output_on_o && tone_input_source_o)[*5];
   endsequence
   sequence s_uvlo_held;
      uvlo_i[*5];
   endsequence
   sequence s_ack_seen;
      $rose(scl_i) && sda_oe_o;
   endsequence

   a_sda_drive_low: assert property (sda_oe_o |-> !sda_o)
      else $error("sda driven high");
   a_ack_whole_high: assert property (s_ack_seen |-> sda_oe_o[*6])
      else $error("pull released in clock high");
   // data changes only shortly after a clock fall
   a_oe_chg_window: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 3) && $past(scl_i, 9))
      else $error("pull changed outside low phase");
   a_uvlo_no_ack: assert property (s_uvlo_held |=> !$rose(sda_oe_o))
      else $error("pull during lockout");
   a_vsel_scl_low: assert property ($changed(volt_sel_o) |-> !scl_i)
      else $error("voltage changed in clock high");
   a_reset_clear: assert property ($fell(rst_i) |-> volt_sel_o == 4'h0 && !sda_oe_o && !tone_output_on_o)
      else $error("state not clear after reset");
   a_tone_excl: assert property (!(tone_ext_pass_o && tone_env_gate_o))
      else $error("both tone paths active");
   a_tone_off: assert property ((!tone_output_on_o)[*2] |-> !tone_ext_pass_o && !tone_env_gate_o)
      else $error("tone active while off");
   a_ext_follow: assert property (s_ext_on |-> tone_ext_pass_o)
      else $error("external tone not passed");
endmodule // scisr_i2c_regs_asserts

bind scisr_i2c_regs scisr_i2c_regs_asserts i_chk (
   .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i), .uvlo_i(uvlo_i),
   .tone_key_input_i(tone_key_input_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .volt_sel_o(volt_sel_o), .tone_output_on_o(tone_output_on_o),
   .tone_input_source_o(tone_input_source_o), .tone_ext_pass_o(tone_ext_pass_o),
   .tone_env_gate_o(tone_env_gate_o)
);

// ===== bench/scisr_host_model.sv
`timescale 1ns/1ps
// ****************************
// bus master model, 125 ns bit
// ****************************
module scisr_host_model (
   // bus
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      pull_o
);
   initial begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   task start;
      #60 pull_o = 1'b1;
      #60 scl_o = 1'b0;
   endtask
   task stop;
      #30 pull_o = 1'b1;
      #35 scl_o = 1'b1;
      #60 pull_o = 1'b0;
      #60;
   endtask
   // one clock per bit, data moves in low phase
   task bit_io(input logic b, output logic r);
      #30 pull_o = ~b;
      #35 scl_o = 1'b1;
      #30 r = sda_i;
      #30 scl_o = 1'b0;
   endtask
   task wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task rbyte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~more, r);
   endtask
endmodule // scisr_host_model

// ===== bench/supply_ctrl_i2c_slave_regs_test.sv
`timescale 1ns/1ps
`include "scisr_regs.vh"
module supply_ctrl_i2c_slave_regs_test;
   logic       mclk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       scl, pull, sda_w, sda_o, sda_oe_o, ack;
   logic       sel = 1'b0, uvlo = 1'b0, key = 1'b0;
   logic [7:0] st1 = 8'hA5, st2 = 8'h3C, rd;
   logic [3:0] volt;
   logic       ton, lps, tsrc, tpass, tgate, olr, bsl, plo, ptl;
   int         err_total = 0, n_tests = 0, cyc = 0;

   // open drain wire with pull-up
   assign sda_w = ~(sda_oe_o | pull);

   scisr_i2c_regs i_scisr_i2c_regs (
      .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .addr_sel_i(sel), .uvlo_i(uvlo), .tone_key_input_i(key),
      .status1_i(st1), .status2_i(st2), .volt_sel_o(volt), .tone_output_on_o(ton),
      .low_power_select_o(lps), .tone_input_source_o(tsrc), .tone_ext_pass_o(tpass),
      .tone_env_gate_o(tgate), .output_limit_range_o(olr), .boost_switch_limit_o(bsl),
      .pulsed_limit_off_o(plo), .pulse_time_long_o(ptl)
   );
   scisr_host_model i_scisr_host_model (.sda_i(sda_w), .scl_o(scl), .pull_o(pull));

   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // runs far beyond the roughly 5.5k cycles the traffic needs
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         tally_and_finish;
      end
   end

   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task pins(input logic s, input logic u, input logic k);
      tick(1);
      sel = s;
      uvlo = u;
      key = k;
   endtask

   task addr(input logic rw, input logic miss, input logic [7:0] exp_ack);
      i_scisr_host_model.start();
      i_scisr_host_model.wbyte({`SCISR_CHIP_ADDR_HI, sel ^ miss, rw}, ack);
      chk("chip ack", ack, exp_ack);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d[$]);
      addr(1'b0, 1'b0, 8'h01);
      i_scisr_host_model.wbyte(a, ack);
      chk("reg ack", ack, 8'h01);
      foreach (d[i]) begin
         i_scisr_host_model.wbyte(d[i], ack);
         chk("data ack", ack, 8'h01);
      end
      i_scisr_host_model.stop();
   endtask

   task rd_chk(input logic [7:0] a, input logic [7:0] e[$]);
      wr(a, '{});
      addr(1'b1, 1'b0, 8'h01);
      foreach (e[i]) begin
         i_scisr_host_model.rbyte(i < e.size() - 1, rd);
         chk("read byte", rd, e[i]);
      end
      i_scisr_host_model.stop();
   endtask

   task t_reset;
      chk("controls", {volt, ton, lps, tsrc, olr, bsl, plo, ptl}, 8'h00);
      rd_chk(`SCISR_ADDR_VOLT, '{8'h00, 8'h00, 8'h00});
      $display("reset test done");
   endtask

   task t_write;
      wr(`SCISR_ADDR_VOLT, '{8'h05, 8'h05, 8'h0F});
      chk("volt", volt, 8'h05);
      chk("tone bits", {ton, lps, tsrc}, 8'h05);
      chk("limit bits", {ptl, plo, bsl, olr}, 8'h0F);
      wr(`SCISR_ADDR_TONE, '{8'h02, 8'h0A});
      chk("tone bits", {ton, lps, tsrc}, 8'h02);
      chk("limit bits", {ptl, plo, bsl, olr}, 8'h0A);
      $display("write test done");
   endtask

   task t_read;
      wr(`SCISR_ADDR_STATUS1, '{8'hFF, 8'hFF});
      rd_chk(`SCISR_ADDR_STATUS1, '{8'hA5, 8'h3C, 8'h05, 8'h02, 8'h0A, 8'h00});
      $display("read test done");
   endtask

   task t_tone;
      wr(`SCISR_ADDR_TONE, '{8'h05});
      pins(1'b0, 1'b0, 1'b1);
      tick(6);
      chk("external path", {tpass, tgate}, 8'h02);
      wr(`SCISR_ADDR_TONE, '{8'h01});
      chk("envelope path", {tpass, tgate}, 8'h01);
      pins(1'b0, 1'b0, 1'b0);
      tick(6);
      chk("key low", {tpass, tgate}, 8'h00);
      $display("tone test done");
   endtask

   task t_refuse;
      pins(1'b0, 1'b1, 1'b0);
      addr(1'b0, 1'b0, 8'h00);
      i_scisr_host_model.stop();
      pins(1'b1, 1'b0, 1'b0);
      addr(1'b0, 1'b1, 8'h00);
      i_scisr_host_model.stop();
      wr(`SCISR_ADDR_VOLT, '{8'h09});
      chk("volt", volt, 8'h09);
      $display("refusal test done");
   endtask

   task t_rst_mid;
      tick(1);
      rst_i = 1'b1;
      tick(4);
      rst_i = 1'b0;
      tick(5);
      chk("controls", {volt, ton, lps, tsrc, olr, bsl, plo, ptl}, 8'h00);
      rd_chk(`SCISR_ADDR_VOLT, '{8'h00, 8'h00, 8'h00});
      $display("mid-run reset test done");
   endtask

   initial begin
      tick(4);
      rst_i = 1'b0;
      tick(5);
      t_reset;
      t_write;
      t_read;
      t_tone;
      t_refuse;
      t_rst_mid;
      tally_and_finish;
   end
endmodule // supply_ctrl_i2c_slave_regs_test
